// File: shared/pmc_pkg.sv
// pmc_pkg: constants and types for the packet memory command control block
package pmc_pkg;
    // register offsets on the device register port
    localparam logic [3:0] OFF_PACKET_MEMORY_COMMAND = 4'h0;
    localparam logic [3:0] OFF_ADAPTER_CONTROL       = 4'hc;
    localparam logic [3:0] OFF_PACKET_NUMBER_SELECT  = 4'h2;
    localparam logic [3:0] OFF_ALLOCATION_RESULT     = 4'h3;
    localparam logic [3:0] OFF_COUNTER               = 4'h6;

    // adapter control field positions
    localparam int BIT_STORE        = 0;
    localparam int BIT_RELOAD       = 1;
    localparam int BIT_NVM_SELECT   = 2;
    localparam int BIT_TX_ERR_EN    = 5;
    localparam int BIT_ROLLOVER_EN  = 6;
    localparam int BIT_LINK_ERR_EN  = 7;
    localparam int BIT_AUTO_RELEASE = 11;
    localparam int BIT_ACCEPT_BAD   = 14;
    localparam logic [15:0] CTL_RESET    = 16'h1210;
    localparam logic [15:0] CTL_WR_MASK  = 16'h48e7;

    // command register layout
    localparam int CMD_OP_LSB = 5;
    localparam int BIT_BUSY   = 0;

    // allocation result layout
    localparam int BIT_ALLOC_FAILED = 7;
    localparam int PKT_W            = 6;

    // timing: worst case reload limit
    localparam int RELOAD_MAX_US = 750;
    localparam int CLK_MHZ       = 100;
    localparam int RELOAD_MAX_CYC = RELOAD_MAX_US * CLK_MHZ;

    typedef enum logic [2:0] {
        OP_NOOP        = 3'h0,
        OP_ALLOCATE    = 3'h1,
        OP_RESET_MEM   = 3'h2,
        OP_RX_POP      = 3'h3,
        OP_RX_POP_FREE = 3'h4,
        OP_FREE_PKT    = 3'h5,
        OP_TX_ENQUEUE  = 3'h6,
        OP_TX_FLUSH    = 3'h7
    } pmc_op_e;

    // one host register access
    typedef struct packed {
        logic        sel;
        logic        wr;
        logic [3:0]  addr;
        logic [15:0] wdata;
    } pmc_bus_s;

    // one memory manager request, a pulse
    typedef struct packed {
        logic             valid;
        pmc_op_e          op;
        logic [PKT_W-1:0] pkt;
    } pmc_mm_req_s;

    // memory manager answer
    typedef struct packed {
        logic             release_done;
        logic             alloc_done;
        logic             alloc_fail;
        logic [PKT_W-1:0] alloc_pkt;
    } pmc_mm_rsp_s;
endpackage

// File: rtl/pmc_nvm_seq.sv
// pmc_nvm_seq: sequences one nonvolatile reload or store with a time limit
`timescale 1ns/1ns
module pmc_nvm_seq #(
    parameter int LIMIT_CYC = pmc_pkg::RELOAD_MAX_CYC
) (
    input  wire logic clk_sys,   // system clock
    input  wire logic rst,       // async reset, high
    input  wire logic start,     // pulse: begin an access
    input  wire logic nvm_done,  // pulse from the serial engine
    output logic      active,    // access in progress
    output logic      finished   // pulse: access ended
);
    import pmc_pkg::*;
    logic [$clog2(LIMIT_CYC+1)-1:0] cnt;

    // run until the engine reports or the limit expires
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            active   <= 1'b1;
            cnt      <= '0;
            finished <= 1'b0;
        end else begin
            finished <= 1'b0;
            if (active) begin
                cnt <= cnt + 1'b1;
                if (nvm_done || cnt == ($bits(cnt))'(LIMIT_CYC - 1)) begin
                    active   <= 1'b0;
                    finished <= 1'b1;
                end
            end else if (start) begin
                active <= 1'b1;
                cnt    <= '0;
            end
        end
    end

    a_limit_bound: assert property (@(posedge clk_sys) disable iff (rst)
        active |-> cnt < ($bits(cnt))'(LIMIT_CYC))
        else $error("nvm access ran past its limit");
endmodule // pmc_nvm_seq

// File: rtl/pmc_cmd_dec.sv
// pmc_cmd_dec: decodes a command write into a memory manager request
`timescale 1ns/1ns
module pmc_cmd_dec (
    input  wire logic        clk_sys,  // system clock
    input  wire logic        rst,      // async reset, high
    input  wire logic        wr_cmd,   // pulse: command register written
    input  wire logic [15:0] wdata,    // written word
    input  wire logic [pmc_pkg::PKT_W-1:0] pkt, // packet number select
    output pmc_pkg::pmc_mm_req_s req   // registered request pulse
);
    import pmc_pkg::*;

    function automatic pmc_op_e op_of(input logic [15:0] d);
        op_of = pmc_op_e'(d[CMD_OP_LSB +: 3]);
    endfunction

    // noop produces no request, others issue one pulse
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            req <= '{valid: 1'b0, op: OP_NOOP, pkt: '0};
        end else begin
            req.valid <= wr_cmd && op_of(wdata) != OP_NOOP;
            req.op    <= op_of(wdata);
            req.pkt   <= pkt;
        end
    end

    a_noop_silent: assert property (@(posedge clk_sys) disable iff (rst)
        wr_cmd && wdata[7:5] == 3'h0 |=> !req.valid)
        else $error("noop issued a request");
endmodule // pmc_cmd_dec

// File: rtl/pmc_top.sv
// pmc_top: adapter control and packet memory command registers
`timescale 1ns/1ns
// Behaviour
// - accept_bad_frames set keeps CRC-failed frames; clear drops and frees them.
// - auto release frees successful tx pages, no completion queue entry.
// - auto release fatal error clears transmitter enable, keeps failing packet.
// - auto release sequence interrupts only on tx empty or fatal error.
// - link error enable merges link transitions; clearing enable acknowledges.
// - rollover enable merges counter rollover; counter read acknowledges.
// - tx error enable merges tx errors; acked by tx enable set or disable.
// - select high touches general word only; low touches config registers.
// - reload and store bits start access and clear themselves on completion.
// - during access reads show reload/store high, writes ignored.
// - worst case reload completes within 750 microseconds.
// - three-bit opcode decoded; code 000 does nothing.
// - opcode 001 allocates tx memory, result and interrupt reported.
// - opcode 010 resets memory manager, packet select and the result's failed flag.
// - opcode 011 pops receive queue head without freeing.
// - opcode 100 pops and frees receive head; busy until done.
// - opcode 101 frees the packet named by packet select.
// - opcode 110 enqueues packet select onto transmit queue.
// - opcode 111 flushes both tx queues, frees nothing.
// - busy at bit 0 during release; busy and failed set at write end.
// - allocation result holds failed flag and packet; failed high at reset.
// - packet select cleared by reset or memory reset command.
module pmc_top #(
    parameter int RELOAD_CYC = pmc_pkg::RELOAD_MAX_CYC
) (
    input  wire logic              clk_sys,      // system clock
    input  wire logic              rst,          // async reset, high
    input  wire pmc_pkg::pmc_bus_s bus,          // host access, one cycle
    output logic [15:0]            rdata,        // registered read data
    output pmc_pkg::pmc_mm_req_s   mm_req,       // memory manager request
    input  wire pmc_pkg::pmc_mm_rsp_s mm_rsp,    // memory manager answer
    input  wire logic              nvm_done,     // serial access finished
    output logic                   nvm_reload,   // reload in progress
    output logic                   nvm_store,    // store in progress
    output logic                   nvm_gp_only,  // access the general word only
    input  wire logic              crc_bad,      // pulse: frame with bad CRC
    output logic                   frame_keep,   // keep bad frame
    output logic                   frame_free,   // pulse: free bad frame
    input  wire logic              tx_done,      // pulse: frame tx complete
    input  wire logic              tx_success,   // tx success flag
    input  wire logic              tx_fatal,     // pulse: fatal tx error
    input  wire logic              tx_seq_empty, // pulse: tx queue drained
    output logic                   tx_free_pkt,  // pulse: free tx pages
    output logic                   tx_log_done,  // pulse: write completion
    output logic                   tx_halt,      // pulse: clear tx enable
    output logic                   tx_empty_irq, // tx empty interrupt flag
    output logic                   tx_irq,       // tx interrupt flag
    input  wire logic              link_change,  // pulse: link transition
    input  wire logic              rollover,     // pulse: counter rollover
    input  wire logic              tx_err_evt,   // pulse: tx enable lost
    input  wire logic              tx_enable_set,// pulse: tx enable written 1
    output logic                   merged_mac_core_irq, // merged interrupt
    output logic                   alloc_irq     // allocation done flag
);
    import pmc_pkg::*;

    logic [15:0] ctl;
    logic [PKT_W-1:0] pkt_sel;
    logic        busy;
    logic        failed;
    logic [PKT_W-1:0] alloc_pkt;
    logic        link_pend, roll_pend, txerr_pend;
    logic        nvm_active, nvm_finished;
    logic        wr, rd, wr_cmd, nvm_start;
    logic        ctl_wr;

    // accesses are ignored while a nonvolatile access runs, except reads
    assign wr      = bus.sel && bus.wr && !nvm_active;
    assign rd      = bus.sel && !bus.wr;
    assign ctl_wr  = wr && bus.addr == OFF_ADAPTER_CONTROL;
    assign wr_cmd  = wr && bus.addr == OFF_PACKET_MEMORY_COMMAND;
    assign nvm_start = ctl_wr && (bus.wdata[BIT_RELOAD] || bus.wdata[BIT_STORE]);

    pmc_nvm_seq #(.LIMIT_CYC(RELOAD_CYC)) u_nvm (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .start    (nvm_start),
        .nvm_done (nvm_done),
        .active   (nvm_active),
        .finished (nvm_finished)
    );

    pmc_cmd_dec u_dec (
        .clk_sys (clk_sys),
        .rst     (rst),
        .wr_cmd  (wr_cmd),
        .wdata   (bus.wdata),
        .pkt     (pkt_sel),
        .req     (mm_req)
    );

    // adapter control register; reload runs from reset
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ctl <= CTL_RESET | (16'h1 << BIT_RELOAD);
        end else if (nvm_finished) begin
            ctl[BIT_RELOAD] <= 1'b0;
            ctl[BIT_STORE]  <= 1'b0;
        end else if (ctl_wr) begin
            ctl <= (ctl & ~CTL_WR_MASK) | (bus.wdata & CTL_WR_MASK);
        end
    end

    // nonvolatile access target and kind
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            nvm_reload  <= 1'b1;
            nvm_store   <= 1'b0;
            nvm_gp_only <= 1'b0;
        end else begin
            nvm_reload  <= nvm_active && ctl[BIT_RELOAD];
            nvm_store   <= nvm_active && ctl[BIT_STORE] && !ctl[BIT_RELOAD];
            nvm_gp_only <= ctl[BIT_NVM_SELECT];
        end
    end

    // packet number select register
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pkt_sel <= '0;
        end else if (wr_cmd && bus.wdata[7:5] == OP_RESET_MEM) begin
            pkt_sel <= '0;
        end else if (wr && bus.addr == OFF_PACKET_NUMBER_SELECT) begin
            pkt_sel <= bus.wdata[PKT_W-1:0];
        end
    end

    // busy flag and allocation result; set wins over completion
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            busy      <= 1'b0;
            failed    <= 1'b1;
            alloc_pkt <= '0;
            alloc_irq <= 1'b0;
        end else begin
            if (mm_rsp.release_done)
                busy <= 1'b0;
            if (mm_rsp.alloc_done) begin
                failed    <= mm_rsp.alloc_fail;
                alloc_pkt <= mm_rsp.alloc_pkt;
                alloc_irq <= !mm_rsp.alloc_fail;
            end
            if (wr_cmd) begin
                unique case (pmc_op_e'(bus.wdata[7:5]))
                    OP_RX_POP_FREE, OP_FREE_PKT: busy <= 1'b1;
                    OP_ALLOCATE: begin
                        failed    <= 1'b1;
                        alloc_irq <= mm_rsp.alloc_done && !mm_rsp.alloc_fail;
                    end
                    OP_RESET_MEM: begin
                        busy      <= 1'b0;
                        failed    <= 1'b1;
                        alloc_irq <= mm_rsp.alloc_done && !mm_rsp.alloc_fail;
                    end
                    default: ;
                endcase
            end
        end
    end

    // bad frame handling
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            frame_keep <= 1'b0;
            frame_free <= 1'b0;
        end else begin
            frame_keep <= crc_bad && ctl[BIT_ACCEPT_BAD];
            frame_free <= crc_bad && !ctl[BIT_ACCEPT_BAD];
        end
    end

    // transmit completion under auto release
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tx_free_pkt  <= 1'b0;
            tx_log_done  <= 1'b0;
            tx_halt      <= 1'b0;
            tx_empty_irq <= 1'b0;
            tx_irq       <= 1'b0;
        end else begin
            tx_free_pkt <= tx_done && tx_success && ctl[BIT_AUTO_RELEASE];
            tx_log_done <= tx_done && !(tx_success && ctl[BIT_AUTO_RELEASE]);
            tx_halt     <= tx_fatal && ctl[BIT_AUTO_RELEASE];
            if (wr_cmd && bus.wdata[7:5] inside {OP_RESET_MEM, OP_TX_FLUSH}) begin
                tx_empty_irq <= 1'b0;
                tx_irq       <= 1'b0;
            end
            if (tx_seq_empty)
                tx_empty_irq <= 1'b1;
            if (tx_fatal || (tx_done && !ctl[BIT_AUTO_RELEASE]))
                tx_irq <= 1'b1;
        end
    end

    // merged mac core interrupt sources; event wins over acknowledge
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            link_pend  <= 1'b0;
            roll_pend  <= 1'b0;
            txerr_pend <= 1'b0;
        end else begin
            if (ctl_wr && !bus.wdata[BIT_LINK_ERR_EN])
                link_pend <= 1'b0;
            if (link_change && ctl[BIT_LINK_ERR_EN])
                link_pend <= 1'b1;
            if (rd && bus.addr == OFF_COUNTER)
                roll_pend <= 1'b0;
            if (rollover && ctl[BIT_ROLLOVER_EN])
                roll_pend <= 1'b1;
            if (tx_enable_set || (ctl_wr && !bus.wdata[BIT_TX_ERR_EN]))
                txerr_pend <= 1'b0;
            if (tx_err_evt && ctl[BIT_TX_ERR_EN])
                txerr_pend <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst)
            merged_mac_core_irq <= 1'b0;
        else
            merged_mac_core_irq <= link_pend | roll_pend | txerr_pend;
    end

    // read data mux, registered
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rdata <= '0;
        end else if (rd) begin
            unique case (bus.addr)
                OFF_ADAPTER_CONTROL:
                    rdata <= nvm_active ? 16'h0003 : ctl;
                OFF_PACKET_MEMORY_COMMAND:
                    rdata <= {15'h0, busy};
                OFF_PACKET_NUMBER_SELECT:
                    rdata <= {10'h0, pkt_sel};
                OFF_ALLOCATION_RESULT:
                    rdata <= {8'h0, failed, 1'b0, alloc_pkt};
                default:
                    rdata <= 16'h0000;
            endcase
        end
    end

    a_busy_set: assert property (@(posedge clk_sys) disable iff (rst)
        wr_cmd && bus.wdata[7:5] == 3'h5 |=> busy)
        else $error("busy not set by release command");
    a_fail_set: assert property (@(posedge clk_sys) disable iff (rst)
        wr_cmd && bus.wdata[7:5] == 3'h1 && !mm_rsp.alloc_done |=> failed)
        else $error("failed not set by allocate");
    a_pkt_clear: assert property (@(posedge clk_sys) disable iff (rst)
        wr_cmd && bus.wdata[7:5] == 3'h2 |=> pkt_sel == '0)
        else $error("packet select not cleared");
    a_write_block: assert property (@(posedge clk_sys) disable iff (rst)
        nvm_active && !nvm_finished |=> $stable(ctl[7:5]))
        else $error("control changed during nvm access");
    a_bad_frame: assert property (@(posedge clk_sys) disable iff (rst)
        crc_bad |=> frame_keep == $past(ctl[BIT_ACCEPT_BAD]))
        else $error("bad frame disposition wrong");
    a_auto_free: assert property (@(posedge clk_sys) disable iff (rst)
        tx_done && tx_success && ctl[BIT_AUTO_RELEASE] |=> tx_free_pkt
        && !tx_log_done)
        else $error("auto release mishandled");
    a_fatal_halt: assert property (@(posedge clk_sys) disable iff (rst)
        tx_fatal && ctl[BIT_AUTO_RELEASE] |=> tx_halt && tx_irq)
        else $error("fatal error not halted");
    a_link_irq: assert property (@(posedge clk_sys) disable iff (rst)
        link_change && ctl[BIT_LINK_ERR_EN] |=> ##1 merged_mac_core_irq)
        else $error("link event not merged");
    a_self_clear: assert property (@(posedge clk_sys) disable iff (rst)
        nvm_finished |=> !ctl[BIT_RELOAD] && !ctl[BIT_STORE])
        else $error("reload or store did not clear");
endmodule // pmc_top

// File: test/pmc_far_model.sv
// pmc_far_model: memory manager and serial engine seen from the block
`timescale 1ns/1ns
module pmc_far_model #(
    parameter int ALLOC_DLY = 6,
    parameter int REL_DLY   = 6,
    parameter int NVM_DLY   = 12
) (
    input  wire logic                 clk_sys,    // system clock
    input  wire logic                 rst,        // async reset, high
    input  wire pmc_pkg::pmc_mm_req_s mm_req,     // request from the block
    input  wire logic                 nvm_reload, // reload running
    input  wire logic                 nvm_store,  // store running
    input  wire logic                 fail_next,  // next allocate fails
    input  wire logic                 hang,       // serial engine never ends
    output pmc_pkg::pmc_mm_rsp_s      mm_rsp,     // answers
    output logic                      nvm_done    // serial access end pulse
);
    import pmc_pkg::*;
    int               acnt;
    int               rcnt;
    int               ncnt;
    logic             nvm_seen;
    logic [PKT_W-1:0] next_pkt;

    // allocation and release answer after a delay
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            mm_rsp   <= '0;
            acnt     <= 0;
            rcnt     <= 0;
            next_pkt <= 6'h05;
        end else begin
            mm_rsp.alloc_done   <= 1'b0;
            mm_rsp.release_done <= 1'b0;
            if (mm_req.valid && mm_req.op == OP_ALLOCATE) acnt <= ALLOC_DLY;
            else if (acnt > 0) acnt <= acnt - 1;
            if (mm_req.valid && (mm_req.op == OP_RX_POP_FREE ||
                mm_req.op == OP_FREE_PKT)) rcnt <= REL_DLY;
            else if (rcnt > 0) rcnt <= rcnt - 1;
            if (acnt == 1) begin
                mm_rsp.alloc_done <= 1'b1;
                mm_rsp.alloc_fail <= fail_next;
                mm_rsp.alloc_pkt  <= fail_next ? ~next_pkt : next_pkt;
                if (!fail_next) next_pkt <= next_pkt + 6'h01;
            end
            if (rcnt == 1) mm_rsp.release_done <= 1'b1;
        end
    end

    // serial engine finishes each access unless told to hang
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            nvm_done <= 1'b0;
            ncnt     <= 0;
            nvm_seen <= 1'b0;
        end else begin
            nvm_done <= 1'b0;
            if (!(nvm_reload || nvm_store)) nvm_seen <= 1'b0;
            else if (!nvm_seen) begin
                nvm_seen <= 1'b1;
                ncnt     <= NVM_DLY;
            end else if (ncnt > 0) begin
                ncnt <= ncnt - 1;
                if (ncnt == 1 && !hang) nvm_done <= 1'b1;
            end
        end
    end
endmodule // pmc_far_model

// File: test/tb.sv
// tb: register level regression of the packet memory command block
`timescale 1ns/1ns
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
    $display("[FAIL] %s exp %h got %h", n, e, g); fails++; end end
module tb;
    import pmc_pkg::*;
    localparam int RCYC = 40;
    logic        clk_sys, rst, nvm_done, nvm_reload, nvm_store, nvm_gp_only;
    logic        tx_success, fail_next, hang, tx_empty_irq, tx_irq;
    logic        frame_keep, frame_free, tx_free_pkt, tx_log_done, tx_halt;
    logic        merged_mac_core_irq, alloc_irq;
    logic [15:0] rdata, d;
    logic [7:0]  ev;
    logic [6:0]  seen;
    pmc_bus_s    bus;
    pmc_mm_req_s mm_req, last_req;
    pmc_mm_rsp_s mm_rsp;
    pmc_op_e     ops [8];
    int          fails, checks_done, k;

    pmc_top #(.RELOAD_CYC(RCYC)) i_dut (.clk_sys(clk_sys), .rst(rst),
        .bus(bus), .rdata(rdata), .mm_req(mm_req), .mm_rsp(mm_rsp),
        .nvm_done(nvm_done), .nvm_reload(nvm_reload), .nvm_store(nvm_store),
        .nvm_gp_only(nvm_gp_only), .crc_bad(ev[0]), .frame_keep(frame_keep),
        .frame_free(frame_free), .tx_done(ev[1]), .tx_success(tx_success),
        .tx_fatal(ev[2]), .tx_seq_empty(ev[3]), .tx_free_pkt(tx_free_pkt),
        .tx_log_done(tx_log_done), .tx_halt(tx_halt),
        .tx_empty_irq(tx_empty_irq), .tx_irq(tx_irq), .link_change(ev[4]),
        .rollover(ev[5]), .tx_err_evt(ev[6]), .tx_enable_set(ev[7]),
        .merged_mac_core_irq(merged_mac_core_irq), .alloc_irq(alloc_irq));

    pmc_far_model i_far (.clk_sys(clk_sys), .rst(rst), .mm_req(mm_req),
        .nvm_reload(nvm_reload), .nvm_store(nvm_store),
        .fail_next(fail_next), .hang(hang), .mm_rsp(mm_rsp),
        .nvm_done(nvm_done));

    // clock
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // collect pulses seen since the last clear
    always @(negedge clk_sys) begin
        seen <= seen | {mm_rsp.alloc_done, mm_req.valid, tx_halt,
                        tx_log_done, tx_free_pkt, frame_free, frame_keep};
        if (mm_req.valid) last_req <= mm_req;
    end

    task automatic wr(input logic [3:0] a, input logic [15:0] w);
        @(posedge clk_sys);
        bus <= '{sel: 1'b1, wr: 1'b1, addr: a, wdata: w};
        @(posedge clk_sys);
        bus.sel <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [15:0] r);
        @(posedge clk_sys);
        bus <= '{sel: 1'b1, wr: 1'b0, addr: a, wdata: 16'h0000};
        @(posedge clk_sys);
        bus.sel <= 1'b0;
        @(negedge clk_sys);
        r = rdata;
    endtask

    task automatic rchk(input logic [3:0] a, input logic [15:0] m, e);
        logic [15:0] r;
        rd(a, r);
        `CHK("register read", e, r & m)
    endtask

    task automatic pulse(input int i);
        @(posedge clk_sys);
        seen    <= '0;
        ev[i]   <= 1'b1;
        @(posedge clk_sys);
        ev      <= '0;
        repeat (3) @(negedge clk_sys);
    endtask

    task automatic wait_nvm;
        repeat (2) @(negedge clk_sys);
        for (k = 0; k < 200 && (nvm_reload || nvm_store); k++)
            @(negedge clk_sys);
        `CHK("serial access end", 1'b0, nvm_reload | nvm_store)
    endtask

    task automatic wait_seen(input int b);
        for (k = 0; k < 50 && !seen[b]; k++) @(negedge clk_sys);
        `CHK("pulse seen", 1'b1, seen[b])
        repeat (2) @(negedge clk_sys);
    endtask

    task automatic conclude;
        if (fails == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // watchdog
    initial begin
        #200000;
        fails++;
        conclude();
    end

    initial begin
        rst = 1'b1; bus = '0; ev = '0; seen = '0; tx_success = 1'b1;
        fail_next = 1'b0; hang = 1'b0; fails = 0; checks_done = 0;
        ops = '{OP_NOOP, OP_ALLOCATE, OP_RX_POP_FREE, OP_FREE_PKT,
                OP_TX_ENQUEUE, OP_RX_POP, OP_TX_FLUSH, OP_RESET_MEM};
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        // reload after reset: polled status, writes dropped
        rchk(OFF_ADAPTER_CONTROL, 16'hffff, 16'h0003);
        wr(OFF_ADAPTER_CONTROL, 16'h4000);
        wait_nvm();
        rchk(OFF_ADAPTER_CONTROL, 16'hffff, CTL_RESET);
        rchk(OFF_ALLOCATION_RESULT, 16'h00ff, 16'h0080);
        rchk(OFF_PACKET_NUMBER_SELECT, 16'h003f, 16'h0000);
        // store of the general word, then reload of the setup
        wr(OFF_ADAPTER_CONTROL, CTL_RESET | 16'h0005);
        repeat (2) @(negedge clk_sys);
        `CHK("store", 2'b11, {nvm_store, nvm_gp_only})
        wait_nvm();
        rchk(OFF_ADAPTER_CONTROL, 16'hffff, CTL_RESET | 16'h0004);
        wr(OFF_ADAPTER_CONTROL, CTL_RESET | 16'h0002);
        repeat (2) @(negedge clk_sys);
        `CHK("reload", 2'b10, {nvm_reload, nvm_gp_only})
        wait_nvm();
        // hung serial engine: time limit ends the reload
        hang <= 1'b1;
        wr(OFF_ADAPTER_CONTROL, CTL_RESET | 16'h0002);
        wait_nvm();
        `CHK("reload limit", 1'b1, k inside {[RCYC - 4:RCYC + 2]})
        hang <= 1'b0;
        // writable and fixed bits
        wr(OFF_ADAPTER_CONTROL, 16'hfffc);
        rchk(OFF_ADAPTER_CONTROL, 16'hffff,
             (16'hfffc & CTL_WR_MASK) | (CTL_RESET & ~CTL_WR_MASK));
        // bad frames kept or freed
        wr(OFF_ADAPTER_CONTROL, CTL_RESET | 16'h4000);
        pulse(0);
        `CHK("bad frame kept", 2'b01, seen[1:0])
        wr(OFF_ADAPTER_CONTROL, CTL_RESET);
        pulse(0);
        `CHK("bad frame freed", 2'b10, seen[1:0])
        pulse(1);
        `CHK("tx logged", 2'b10, seen[3:2])
        // automatic release
        wr(OFF_ADAPTER_CONTROL, CTL_RESET | 16'h0800);
        wr(OFF_PACKET_MEMORY_COMMAND, {8'h00, OP_TX_FLUSH, 5'h00});
        pulse(1);
        `CHK("auto free", 2'b01, seen[3:2])
        `CHK("no tx irq", 2'b00, {tx_irq, tx_empty_irq})
        pulse(2);
        `CHK("fatal", 3'b110, {seen[4], tx_irq, seen[2]})
        pulse(3);
        `CHK("tx empty irq", 1'b1, tx_empty_irq)
        // merged interrupt sources
        wr(OFF_ADAPTER_CONTROL, CTL_RESET);
        pulse(4);
        `CHK("link masked", 1'b0, merged_mac_core_irq)
        wr(OFF_ADAPTER_CONTROL, CTL_RESET | 16'h0080);
        pulse(4);
        `CHK("link irq", 1'b1, merged_mac_core_irq)
        wr(OFF_ADAPTER_CONTROL, CTL_RESET | 16'h0040);
        repeat (3) @(negedge clk_sys);
        `CHK("link ack", 1'b0, merged_mac_core_irq)
        pulse(5);
        `CHK("rollover irq", 1'b1, merged_mac_core_irq)
        rd(OFF_COUNTER, d);
        repeat (3) @(negedge clk_sys);
        `CHK("rollover ack", 1'b0, merged_mac_core_irq)
        wr(OFF_ADAPTER_CONTROL, CTL_RESET | 16'h0020);
        pulse(6);
        `CHK("tx err irq", 1'b1, merged_mac_core_irq)
        pulse(7);
        `CHK("tx enable ack", 1'b0, merged_mac_core_irq)
        pulse(6);
        wr(OFF_ADAPTER_CONTROL, CTL_RESET);
        repeat (3) @(negedge clk_sys);
        `CHK("tx err disable ack", 1'b0, merged_mac_core_irq)
        // every opcode, reserved bits written as ones
        wr(OFF_PACKET_NUMBER_SELECT, 16'h002a);
        for (int i = 0; i < 8; i++) begin
            seen <= '0;
            wr(OFF_PACKET_MEMORY_COMMAND, {8'hff, ops[i], 5'h1e});
            repeat (2) @(negedge clk_sys);
            if (i > 0) begin
                `CHK("request op", ops[i], last_req.op)
                `CHK("request pkt", 6'h2a, last_req.pkt)
            end
            if (ops[i] inside {OP_RX_POP_FREE, OP_FREE_PKT}) begin
                rd(OFF_PACKET_MEMORY_COMMAND, d);
                `CHK("busy set", 1'b1, d[BIT_BUSY])
                for (k = 0; k < 30 && d[BIT_BUSY] !== 1'b0; k++)
                    rd(OFF_PACKET_MEMORY_COMMAND, d);
                `CHK("busy clear", 1'b0, d[BIT_BUSY])
            end else if (ops[i] == OP_ALLOCATE) begin
                wait_seen(6);
                rchk(OFF_ALLOCATION_RESULT, 16'h00ff, 16'h0005);
                `CHK("alloc irq", 1'b1, alloc_irq)
            end else begin
                rchk(OFF_PACKET_MEMORY_COMMAND, 16'h0001, 16'h0000);
            end
        end
        rchk(OFF_PACKET_NUMBER_SELECT, 16'h003f, 16'h0000);
        rchk(OFF_ALLOCATION_RESULT, 16'h0080, 16'h0080);
        `CHK("alloc irq cleared", 1'b0, alloc_irq)
        // failing allocation: flag set at the write, stays set
        fail_next <= 1'b1;
        seen      <= '0;
        wr(OFF_PACKET_MEMORY_COMMAND, {8'h00, OP_ALLOCATE, 5'h00});
        rchk(OFF_ALLOCATION_RESULT, 16'h0080, 16'h0080);
        wait_seen(6);
        rchk(OFF_ALLOCATION_RESULT, 16'h0080, 16'h0080);
        `CHK("no alloc irq", 1'b0, alloc_irq)
        conclude();
    end
endmodule // tb
